// *** rtl/stp_pkg.sv ***
// Purpose: Constants and types for the sensor output test-pattern block
// Assumes: 16-bit registers on a 32-bit APB, byte address = 4 x register index
// Notes:   Overview list below
//
// Overview of operation
// - Flag a channel fault when fewer black samples than needed were gathered
// - Fault status holds eight read-only channel bits in its low byte
// - Enable bit replaces sensor pixels with a synthesized pattern on all lanes
// - Increment bit makes the pattern step each word, else it stays constant
// - PRBS bit drives a pseudo-random sequence onto the lanes instead of pixels
// - Framing bit sends patterns inside frame/line structure, else continuous stream
// - Each lane has its own constant from an 8-bit low and 2-bit high part
// - Needed black samples equal two to the programmed exponent
package stp_pkg;

  localparam int unsigned LANES      = 4;
  localparam int unsigned PIX_W      = 10;
  localparam int unsigned CHANS      = 8;
  localparam int unsigned BCNT_W     = 9;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_BLACKCAL  = 8'h80;
  localparam logic [7:0]  IDX_FAULT     = 8'h89;
  localparam logic [7:0]  IDX_RSVD_A    = 8'h8A;
  localparam logic [7:0]  IDX_RSVD_B    = 8'h8B;
  localparam logic [7:0]  IDX_RSVD_C    = 8'h8C;
  localparam logic [7:0]  IDX_RSVD_ONES = 8'h8D;
  localparam logic [7:0]  IDX_TEST_CTRL = 8'h90;
  localparam logic [7:0]  IDX_PAT_LO01  = 8'h92;
  localparam logic [7:0]  IDX_PAT_LO23  = 8'h93;
  localparam logic [7:0]  IDX_PAT_HI    = 8'h96;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hA0;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hA1;

  // Reset values
  localparam logic [15:0] RST_BLACKCAL  = 16'h4008;
  localparam logic [15:0] RST_RSVD_ONES = 16'hFFFF;
  localparam logic [3:0]  RST_TEST_CTRL = 4'h0;
  localparam logic [15:0] RST_PAT_LO01  = 16'h0100;
  localparam logic [15:0] RST_PAT_LO23  = 16'h0302;
  localparam logic [7:0]  RST_PAT_HI    = 8'h00;
  localparam logic [1:0]  RST_IRQ       = 2'h0;

  // Field positions
  localparam int unsigned BIT_PAT_EN    = 0;
  localparam int unsigned BIT_INC       = 1;
  localparam int unsigned BIT_PRBS      = 2;
  localparam int unsigned BIT_FRAMED    = 3;
  localparam int unsigned BSAMP_LSB     = 8;
  localparam int unsigned BSAMP_W       = 3;
  localparam int unsigned IRQ_FAULT     = 0;
  localparam int unsigned IRQ_FRAME     = 1;

  // PRBS seed, any nonzero value
  localparam logic [14:0] PRBS_SEED     = 15'h7FFF;

  typedef logic [LANES-1:0][PIX_W-1:0] stp_lane_data_t;

  // Pixel word arriving from the readout side
  typedef struct packed {
    logic           fv;
    logic           lv;
    stp_lane_data_t data;
  } stp_pix_s;

  // Word leaving toward the frame receiver
  typedef struct packed {
    logic           dv;
    logic           fv;
    logic           lv;
    stp_lane_data_t data;
  } stp_out_s;

  // Black calibration result from the calibration engine
  typedef struct packed {
    logic              done;
    logic [2:0]        chan;
    logic [BCNT_W-1:0] count;
  } stp_bcal_s;

endpackage

// *** rtl/stp_prbs.sv ***
// Purpose: Pseudo-random word source for the lanes
// Assumes: One step per output word
// Notes:   x^15 + x^14 + 1 LFSR, low bits form the word
`timescale 1ns/10ps
`default_nettype none
module stp_prbs #(
  parameter int unsigned W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         load_i,
  input  wire logic         step_i,
  output logic [W-1:0]      data_o
);
  import stp_pkg::*;

  logic [14:0] lfsr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register, reload on request
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfsr_reg <= PRBS_SEED;
    end else if (load_i) begin
      lfsr_reg <= PRBS_SEED;
    end else if (step_i) begin
      lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
    end
  end

  // Registered word output
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= '0;
    end else begin
      data_o <= lfsr_reg[W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** rtl/stp_top.sv ***
// Purpose: Test-pattern insertion on the output lanes plus black-cal fault status
// Assumes: Pixel clock and pixel pins come from outside and are synchronised here
// Notes:   APB slave with zero wait states; one level interrupt
`timescale 1ns/10ps
`default_nettype none
module stp_top (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Readout side, asynchronous pins
  input  wire logic              pix_clk_i,
  input  wire stp_pkg::stp_pix_s pix_i,
  // Calibration engine, same clock
  input  wire stp_pkg::stp_bcal_s bcal_i,
  // Toward frame receiver
  output stp_pkg::stp_out_s      out_o,
  output logic                   irq_o
);
  import stp_pkg::*;

  logic [2:0]           pclk_sync_reg;
  stp_pix_s             pix_s1_reg;
  stp_pix_s             pix_s2_reg;
  logic                 word_stb;
  logic                 lv_prev_reg;
  logic                 fv_prev_reg;
  logic                 line_start;
  logic                 frame_start;
  logic [15:0]          blackcal_reg;
  logic [3:0]           test_ctrl_reg;
  logic [15:0]          pat_lo01_reg;
  logic [15:0]          pat_lo23_reg;
  logic [7:0]           pat_hi_reg;
  logic [CHANS-1:0]     fault_reg;
  logic [1:0]           irq_stat_reg;
  logic [1:0]           irq_mask_reg;
  logic [1:0]           irq_event;
  stp_lane_data_t       pat_base;
  stp_lane_data_t       pat_cnt_reg;
  logic [PIX_W-1:0]     prbs_word;
  logic                 framed;
  logic                 in_line;
  logic                 advance;
  logic                 wr_en;
  logic                 rd_en;
  logic [7:0]           idx;
  logic                 idx_hit;
  logic [BCNT_W-1:0]    need_samples;
  logic                 bcal_fault;
  logic [31:0]          rd_data;

  // Threshold from exponent
  function automatic logic [BCNT_W-1:0] samples_needed(input logic [BSAMP_W-1:0] e);
    samples_needed = BCNT_W'(1) << e;
  endfunction

  // Selects one lane's field from a packed register pair
  function automatic logic [7:0] lane_low(input logic [15:0] r, input logic hi);
    lane_low = hi ? r[15:8] : r[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign idx      = paddr_i[9:2];
  assign wr_en    = psel_i & penable_i & pwrite_i & idx_hit;
  assign rd_en    = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  // Address hit table
  always_comb begin
    case (idx)
      IDX_BLACKCAL, IDX_FAULT, IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_ONES,
      IDX_TEST_CTRL, IDX_PAT_LO01, IDX_PAT_LO23, IDX_PAT_HI,
      IDX_IRQ_STAT, IDX_IRQ_MASK: idx_hit = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
      default: idx_hit = 1'b0;
    endcase
  end

  // Error on unmapped access
  assign pslverr_o = psel_i & penable_i & ~idx_hit;

  // Read mux, upper half reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_BLACKCAL:  rd_data[15:0] = blackcal_reg;
      IDX_FAULT:     rd_data[7:0]  = fault_reg;
      IDX_RSVD_ONES: rd_data[15:0] = RST_RSVD_ONES;
      IDX_TEST_CTRL: rd_data[3:0]  = test_ctrl_reg;
      IDX_PAT_LO01:  rd_data[15:0] = pat_lo01_reg;
      IDX_PAT_LO23:  rd_data[15:0] = pat_lo23_reg;
      IDX_PAT_HI:    rd_data[7:0]  = pat_hi_reg;
      IDX_IRQ_STAT:  rd_data[1:0]  = irq_stat_reg;
      IDX_IRQ_MASK:  rd_data[1:0]  = irq_mask_reg;
      default:       rd_data = 32'h0000_0000;
    endcase
    if (!idx_hit) begin
      rd_data = 32'h0000_0000;
    end
  end

  // Registered read data
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blackcal_reg  <= RST_BLACKCAL;
      test_ctrl_reg <= RST_TEST_CTRL;
      pat_lo01_reg  <= RST_PAT_LO01;
      pat_lo23_reg  <= RST_PAT_LO23;
      pat_hi_reg    <= RST_PAT_HI;
      irq_mask_reg  <= RST_IRQ;
    end else if (wr_en) begin
      case (idx)
        IDX_BLACKCAL:  blackcal_reg  <= pwdata_i[15:0];
        IDX_TEST_CTRL: test_ctrl_reg <= pwdata_i[3:0];
        IDX_PAT_LO01:  pat_lo01_reg  <= pwdata_i[15:0];
        IDX_PAT_LO23:  pat_lo23_reg  <= pwdata_i[15:0];
        IDX_PAT_HI:    pat_hi_reg    <= pwdata_i[7:0];
        IDX_IRQ_MASK:  irq_mask_reg  <= pwdata_i[1:0];
        default:       irq_mask_reg  <= irq_mask_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Black calibration fault status
  // threshold exponent
  assign need_samples = samples_needed(blackcal_reg[BSAMP_LSB +: BSAMP_W]);
  assign bcal_fault   = bcal_i.count < need_samples;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_reg <= '0;
    end else if (bcal_i.done) begin
      fault_reg[bcal_i.chan] <= bcal_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, pixel clock edge detect
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pclk_sync_reg <= 3'h0;
      pix_s1_reg    <= '0;
      pix_s2_reg    <= '0;
    end else begin
      pclk_sync_reg <= {pclk_sync_reg[1:0], pix_clk_i};
      pix_s1_reg    <= pix_i;
      pix_s2_reg    <= pix_s1_reg;
    end
  end

  assign word_stb = pclk_sync_reg[1] & ~pclk_sync_reg[2];

  // Line and frame edge tracking
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lv_prev_reg <= 1'b0;
      fv_prev_reg <= 1'b0;
    end else if (word_stb) begin
      lv_prev_reg <= pix_s2_reg.lv;
      fv_prev_reg <= pix_s2_reg.fv;
    end
  end

  assign line_start  = word_stb & pix_s2_reg.lv & ~lv_prev_reg;
  assign frame_start = word_stb & pix_s2_reg.fv & ~fv_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generation
  // lane constants
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      pat_base[i] = {pat_hi_reg[2*i +: 2], lane_low(i < 2 ? pat_lo01_reg : pat_lo23_reg, i[0])};
    end
  end

  assign framed  = test_ctrl_reg[BIT_FRAMED];
  assign in_line = pix_s2_reg.fv & pix_s2_reg.lv;
  assign advance = word_stb & (framed ? in_line : 1'b1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pat_cnt_reg <= '0;
    end else if (!test_ctrl_reg[BIT_INC] || !test_ctrl_reg[BIT_PAT_EN]) begin
      pat_cnt_reg <= pat_base;
    end else if (framed && line_start) begin
      // Line opens on the constant, so the counter moves one past it
      for (int i = 0; i < LANES; i++) begin
        pat_cnt_reg[i] <= pat_base[i] + PIX_W'(1);
      end
    end else if (advance) begin
      for (int i = 0; i < LANES; i++) begin
        pat_cnt_reg[i] <= pat_cnt_reg[i] + PIX_W'(1);
      end
    end
  end

  stp_prbs #(
    .W (PIX_W)
  ) u_prbs (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (~test_ctrl_reg[BIT_PRBS]),
    .step_i    (advance),
    .data_o    (prbs_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output word, one per rising pixel clock edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_o <= '0;
    end else begin
      out_o.dv <= 1'b0;
      if (word_stb) begin
        if (test_ctrl_reg[BIT_PRBS]) begin
          for (int i = 0; i < LANES; i++) begin
            out_o.data[i] <= prbs_word;
          end
        end else if (test_ctrl_reg[BIT_PAT_EN]) begin
          out_o.data <= (framed && line_start) ? pat_base : pat_cnt_reg;
        end else begin
          out_o.data <= pix_s2_reg.data;
        end
        if ((test_ctrl_reg[BIT_PRBS] | test_ctrl_reg[BIT_PAT_EN]) & ~framed) begin
          out_o.dv <= 1'b1;
          out_o.fv <= 1'b0;
          out_o.lv <= 1'b0;
        end else begin
          out_o.dv <= in_line;
          out_o.fv <= pix_s2_reg.fv;
          out_o.lv <= pix_s2_reg.lv;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-clear
  assign irq_event[IRQ_FAULT] = bcal_i.done & bcal_fault;
  assign irq_event[IRQ_FRAME] = frame_start;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_reg <= RST_IRQ;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_en && idx == IDX_IRQ_STAT) ? pwdata_i[1:0] : 2'h0)) | irq_event;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule
`default_nettype wire

// *** verification/stp_chk.sv ***
// Purpose: Port checks for the test-pattern block
// Assumes: Control is written only while no word is in flight
// Notes:   Shadows the pattern registers from APB writes
`timescale 1ns/10ps
`default_nettype none
module stp_chk (
  input wire logic             clk_i,
  input wire logic             reset_n_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [11:0]      paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  input wire stp_pkg::stp_out_s out_o
);
  import stp_pkg::*;
  logic [3:0]  ctl;
  logic [15:0] l01;
  logic [15:0] l23;
  logic [7:0]  hi;
  wire logic   acc = psel_i && penable_i;
  // Lane constants, lane 3 on top
  wire logic [39:0] cst = {hi[7:6], l23[15:8], hi[5:4], l23[7:0], hi[3:2], l01[15:8], hi[1:0], l01[7:0]};
  ////////////////////////////////////////
  // Shadow of control and constants
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl <= RST_TEST_CTRL;
      l01 <= RST_PAT_LO01;
      l23 <= RST_PAT_LO23;
      hi  <= RST_PAT_HI;
    end else if (acc && pwrite_i) begin
      case (paddr_i[9:2])
        IDX_TEST_CTRL: ctl <= pwdata_i[3:0];
        IDX_PAT_LO01:  l01 <= pwdata_i[15:0];
        IDX_PAT_LO23:  l23 <= pwdata_i[15:0];
        IDX_PAT_HI:    hi <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  bus_ready_a: assert property (acc |-> pready_o)
    else $error("access without ready");
  unmapped_err_a: assert property (acc && paddr_i[9:2] < 8'h80 |-> pslverr_o)
    else $error("unmapped access without error");
  fault_byte_a: assert property (acc && !pwrite_i && paddr_i[9:2] == IDX_FAULT |-> prdata_o[31:8] == 24'h0)
    else $error("fault status upper bits set");
  valid_pulse_a: assert property (out_o.dv |=> !out_o.dv)
    else $error("valid longer than one cycle");
  unframed_idle_a: assert property (out_o.dv && (ctl[0] || ctl[2]) && !ctl[3] |-> !out_o.fv && !out_o.lv)
    else $error("unframed word carries sync");
  framed_sync_a: assert property (out_o.dv && (ctl[3] || !(ctl[0] || ctl[2])) |-> out_o.fv && out_o.lv)
    else $error("framed word outside line");
  const_lane_a: assert property (out_o.dv && ctl[2:0] == 3'h1 |-> out_o.data == cst)
    else $error("constant pattern wrong");
  prbs_lanes_a: assert property (out_o.dv && ctl[2] |-> out_o.data[0] == out_o.data[1] &&
    out_o.data[2] == out_o.data[3] && out_o.data[0] == out_o.data[2])
    else $error("prbs lanes differ");
  cover property (out_o.dv && ctl[2]);
  cover property (out_o.dv && ctl[1:0] == 2'h3);
  cover property (acc && pslverr_o);
endmodule
bind stp_top stp_chk chk_u (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .out_o);
`default_nettype wire

// *** verification/stp_rx.sv ***
// Purpose: Frame receiver model on the lanes
// Assumes: One word per valid pulse
// Notes:   Keeps the last two words for the bench
`timescale 1ns/10ps
`default_nettype none
module stp_rx (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire stp_pkg::stp_out_s in_i,
  output logic                   stb_o,
  output stp_pkg::stp_lane_data_t cur_o,
  output stp_pkg::stp_lane_data_t prv_o
);
  import stp_pkg::*;
  // Capture each valid word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stb_o <= 1'b0;
      cur_o <= '0;
      prv_o <= '0;
    end else begin
      stb_o <= in_i.dv;
      if (in_i.dv) begin
        cur_o <= in_i.data;
        prv_o <= cur_o;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/stp_top_tb.sv ***
// Purpose: Self-checking bench for the test-pattern block
// Assumes: Words are sent only while control is steady
// Notes:   Notes queued by drivers, checked by one monitor
`timescale 1ns/10ps
`default_nettype none
module stp_top_tb;
  import stp_pkg::*;
  logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pix_clk_i = 0;
  logic run = 0, fr = 0, pready_o, pslverr_o, irq_o, stb;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rs = 32'hAA16D675, rq[$];
  stp_pix_s pix_i = '0;
  stp_bcal_s bcal_i = '0;
  stp_out_s out_o;
  stp_lane_data_t cur, prv, cst, wq[$];
  int error_cnt = 0, tests_run = 0, mode = 0, lm = 0;
  logic [7:0] ix [11] = '{IDX_FAULT, IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_ONES,
    IDX_TEST_CTRL, IDX_BLACKCAL, IDX_PAT_LO01, IDX_PAT_LO23, IDX_PAT_HI, 8'h00};
  logic [15:0] ev [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, RST_BLACKCAL,
    RST_PAT_LO01, RST_PAT_LO23, 16'h0, 16'h0};
  always #5 clk_i = ~clk_i;
  // Link clock, held low between bursts
  always #62.5 pix_clk_i = run ? ~pix_clk_i : 1'b0;
  stp_top dut_u (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .pix_clk_i, .pix_i, .bcal_i, .out_o, .irq_o);
  stp_rx rx_u (.clk_i, .reset_n_i, .in_i(out_o), .stb_o(stb), .cur_o(cur), .prv_o(prv));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic give_verdict();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic bad(input string m);
    $display("unexpected at %0t: %s", $time, m);
    error_cnt++;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) bad(m);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'h0, a, 2'h0};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 64);
    if (k >= 64) begin
      bad("no ready");
      give_verdict();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cal(input logic [2:0] e, input logic [7:0] f);
    apb(1'b1, IDX_BLACKCAL, {21'h0, e, 8'h08});
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      bcal_i <= '{1'b1, c[2:0], f[c] ? (9'h1 << e) - 9'h1 : 9'h1 << e};
      @(posedge clk_i);
      bcal_i.done <= 1'b0;
    end
    rd(IDX_FAULT, {24'h0, f});
  endtask
  task automatic cfg(input logic [3:0] c, input int m);
    apb(1'b1, IDX_TEST_CTRL, {28'h0, c});
    mode = m;
    fr = c[3];
  endtask
  task automatic words(input int n, input logic lv);
    stp_lane_data_t d;
    for (int i = 0; i < n; i++) begin
      rs = lfsr(rs);
      d = {rs[19:0], rs[31:12]};
      pix_i <= '{1'b1, lv, d};
      if (mode < 2 && (lv || mode == 1 && !fr)) wq.push_back(mode == 1 ? cst : d);
      if (i == 0) repeat (4) @(posedge clk_i);
      run <= 1'b1;
      @(negedge pix_clk_i);
      @(posedge clk_i);
    end
    run <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  // Monitor: reads and received words
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
      chk(prdata_o === (rq.size() > 0 ? rq.pop_front() : 'x), "read data");
    if (stb) begin
      if (mode < 2) chk(cur === (wq.size() > 0 ? wq.pop_front() : 'x), "word data");
      else if (mode == 2 && lm == 2) chk(cur[0] === prv[0] + 10'h1, "no increment");
      else if (mode == 3 && lm == 3) chk(cur !== prv, "prbs stuck");
      lm = mode;
    end
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    bad("watchdog");
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    foreach (ix[i]) rd(ix[i], {16'h0, ev[i]});
    apb(1'b1, IDX_FAULT, 32'hFF);
    apb(1'b1, IDX_RSVD_ONES, 32'h0);
    rd(IDX_FAULT, 32'h0);
    rd(IDX_RSVD_ONES, 32'hFFFF);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    cal(3'h3, 8'hAA);
    cal(3'h0, 8'h01);
    cal(3'h7, rs[7:0]);
    chk(irq_o === 1'b1, "irq low");
    apb(1'b1, IDX_IRQ_MASK, 32'h0);
    @(posedge clk_i);
    chk(irq_o === 1'b0, "irq not masked");
    apb(1'b1, IDX_IRQ_STAT, 32'h1);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    @(posedge clk_i);
    chk(irq_o === 1'b0, "irq not cleared");
    words(4, 1'b1);
    words(2, 1'b0);
    rd(IDX_IRQ_STAT, 32'h2);
    rs = lfsr(rs);
    apb(1'b1, IDX_PAT_LO01, rs);
    apb(1'b1, IDX_PAT_LO23, {rs[15:0], rs[31:16]});
    apb(1'b1, IDX_PAT_HI, {24'h0, ~rs[7:0]});
    cst = {~rs[7:6], rs[31:24], ~rs[5:4], rs[23:16], ~rs[3:2], rs[15:8], ~rs[1:0], rs[7:0]};
    cfg(4'h1, 1);
    words(3, 1'b0);
    cfg(4'h9, 1);
    words(2, 1'b0);
    words(2, 1'b1);
    apb(1'b1, IDX_PAT_LO01, 32'hFF);
    apb(1'b1, IDX_PAT_HI, 32'h3);
    cfg(4'h3, 2);
    words(5, 1'b0);
    cfg(4'h5, 3);
    words(5, 1'b0);
    cfg(4'hC, 3);
    words(3, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(rq.size() == 0 && wq.size() == 0, "notes left");
    give_verdict();
  end
endmodule
`default_nettype wire
